// ===== psadc_pkg.sv
package psadc_pkg;
	localparam int DATA_W = 8;
	localparam int CONV_CYCLES = 16;
	localparam int CNT_W = 5;
	localparam int SAMPLE_CYCLES = 6;
	localparam int CLK_PERIOD_NS = 50;
	localparam int AUTO_PD_NS = 50;
	localparam int AUTO_PD_CYCLES = (AUTO_PD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
	localparam int ADDR_HI_POS = 7;
	localparam int ADDR_LO_POS = 6;
	localparam logic [1:0] ADDR_CR0 = 2'h0;
	localparam logic [1:0] ADDR_CR1 = 2'h1;
	localparam int START_SEL_POS = 5;
	localparam int EOC_MODE_POS = 4;
	localparam int CLK_SEL_POS = 3;
	localparam int SW_PD_POS = 2;
	localparam int TWOS_POS = 1;
	localparam logic [5:0] CTRL_RESET = 6'h00;

	typedef struct packed {
		logic chipSelN;
		logic readN;
		logic writeN;
		logic startN;
	} psadc_strobes_t;

	typedef enum logic [1:0] {
		PSADC_IDLE = 2'b00,
		PSADC_SAMPLE = 2'b01,
		PSADC_CONVERT = 2'b10,
		PSADC_DONE = 2'b11
	} psadc_state_t;
endpackage

// ===== psadc_sar.sv
`timescale 1ns/10ps
module psadc_sar #(
	parameter int WIDTH = psadc_pkg::DATA_W
) (
	input wire logic core_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire logic startConv,
	input wire logic compHigh,
	output logic [WIDTH-1:0] trialCode,
	output logic busy,
	output logic done
);
	logic [WIDTH-1:0] bitMask_q;
	logic [WIDTH-1:0] code_q;

	// One bit resolved per step, MSB first
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			bitMask_q <= '0;
			code_q <= '0;
			done <= 1'b0;
		end
		else if (clkEn)
		begin
			done <= 1'b0;
			if (startConv)
			begin
				bitMask_q <= {1'b1, {(WIDTH-1){1'b0}}};
				code_q <= {1'b1, {(WIDTH-1){1'b0}}};
			end
			else if (bitMask_q != '0)
			begin
				if (!compHigh)
					code_q <= (code_q & ~bitMask_q) | (bitMask_q >> 1);
				else
					code_q <= code_q | (bitMask_q >> 1);
				bitMask_q <= bitMask_q >> 1;
				done <= (bitMask_q[0] == 1'b1);
			end
		end
	end

	assign trialCode = code_q;
	assign busy = (bitMask_q != '0);
endmodule

// ===== psadc_top.sv
// What this block does
// - Bus acts only with chip select low
// - Start pin falls: sample; rises: convert
// - Read strobe falling drives result on bus
// - Config captured at write strobe rising edge
// - Software start: write rising starts sampling
// - Write tied low means hardware configuration
// - Top two bus bits select register
// - Dummy read with write low loads defaults
// - Two control registers: start, clock and powerdown in the first, output format in the second
// - Auto power-down fixed time after conversion
// - Software power-down under host control
// - Successive approximation, 8-bit result
// - Conversion ends after a fixed clock count
// - Data lines driven only during reads
// - Bits 7,6 address; six bits data
// - Each conversion takes sixteen clocks
// - Self-configuration writes zeros to both
// - No read one clock after: power down
`timescale 1ns/10ps
module psadc_top #(
	parameter int WIDTH = psadc_pkg::DATA_W
) (
	input wire logic core_clk,
	input wire logic ext_clk,
	input wire logic reset_n,
	input wire logic clkEn,
	input wire psadc_pkg::psadc_strobes_t strobesIn,
	input wire logic [WIDTH-1:0] dataIn,
	output logic [WIDTH-1:0] dataOut,
	output logic dataOe,
	input wire logic compHigh,
	output logic [WIDTH-1:0] dacCode,
	output logic sampleHold,
	output logic intEocN,
	output logic autoPowerDown,
	output logic swPowerDown,
	output logic useExtClk
);
	psadc_pkg::psadc_strobes_t sync1_q, sync2_q, prev_q;
	logic [1:0] extSync_q;
	logic extPrev_q;
	logic [5:0] ctrlZero_q, ctrlOne_q;
	psadc_pkg::psadc_state_t state_q;
	logic [psadc_pkg::CNT_W-1:0] cnt_q;
	logic [WIDTH-1:0] result_q;
	logic wrSeenHigh_q;
	logic [1:0] syncValid_q;
	logic [WIDTH-1:0] dataSync1_q, dataSync2_q;
	logic [psadc_pkg::CNT_W-1:0] convTicks_q;
	logic [1:0] idleCnt_q;
	logic csActive, rdFall, rdRise, wrRise, stFall, stRise, tick, startConv, sarBusy, sarDone;
	logic [WIDTH-1:0] trial;

	// Pins are asynchronous to core_clk
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			sync1_q <= '1;
			sync2_q <= '1;
			prev_q <= '1;
			extSync_q <= 2'h0;
			extPrev_q <= 1'b0;
			dataSync1_q <= '0;
			dataSync2_q <= '0;
			syncValid_q <= 2'h0;
		end
		else if (clkEn)
		begin
			sync1_q <= strobesIn;
			sync2_q <= sync1_q;
			prev_q <= sync2_q;
			extSync_q <= {extSync_q[0], ext_clk};
			extPrev_q <= extSync_q[1];
			dataSync1_q <= dataIn;
			dataSync2_q <= dataSync1_q;
			syncValid_q <= {syncValid_q[0], 1'b1};
		end
	end

	assign csActive = !sync2_q.chipSelN;
	assign rdFall = csActive && prev_q.readN && !sync2_q.readN;
	assign rdRise = csActive && !prev_q.readN && sync2_q.readN;
	assign wrRise = csActive && !prev_q.writeN && sync2_q.writeN;
	assign stFall = prev_q.startN && !sync2_q.startN;
	assign stRise = !prev_q.startN && sync2_q.startN;
	// External clock sampled as an enable; internal oscillator is core_clk
	assign tick = ctrlZero_q[psadc_pkg::CLK_SEL_POS] ? (extSync_q[1] && !extPrev_q) : 1'b1;

	// Write strobe never seen high means pin is strapped low
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			wrSeenHigh_q <= 1'b0;
		// Sync stages reset to ones, so trust them only once real pin levels arrived
		else if (clkEn && syncValid_q[1] && sync2_q.writeN)
			wrSeenHigh_q <= 1'b1;
	end

	// Control registers
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			ctrlZero_q <= psadc_pkg::CTRL_RESET;
			ctrlOne_q <= psadc_pkg::CTRL_RESET;
		end
		else if (clkEn)
		begin
			if (!wrSeenHigh_q && rdFall)
			begin
				ctrlZero_q <= psadc_pkg::CTRL_RESET;
				ctrlOne_q <= psadc_pkg::CTRL_RESET;
			end
			else if (wrSeenHigh_q && wrRise)
			begin
				// Bus synced alongside the strobes, so data and edge line up
				unique case ({dataSync2_q[psadc_pkg::ADDR_HI_POS], dataSync2_q[psadc_pkg::ADDR_LO_POS]})
					psadc_pkg::ADDR_CR0: ctrlZero_q <= dataSync2_q[5:0];
					psadc_pkg::ADDR_CR1: ctrlOne_q <= dataSync2_q[5:0];
					default: ;
				endcase
			end
		end
	end

	psadc_sar #(.WIDTH(WIDTH)) sarCore (
		.core_clk(core_clk),
		.reset_n(reset_n),
		.clkEn(clkEn && tick),
		.startConv(startConv),
		.compHigh(compHigh),
		.trialCode(trial),
		.busy(sarBusy),
		.done(sarDone)
	);

	// Comparator must judge the trial held now, not last cycle's copy
	assign dacCode = trial;

	assign startConv = (state_q == psadc_pkg::PSADC_SAMPLE) &&
		(ctrlZero_q[psadc_pkg::START_SEL_POS] ? (cnt_q == 5'(psadc_pkg::SAMPLE_CYCLES - 1)) : stRise);

	// Sample/convert sequencer
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			state_q <= psadc_pkg::PSADC_IDLE;
			cnt_q <= '0;
			result_q <= '0;
		end
		else if (clkEn && tick)
		begin
			unique case (state_q)
				psadc_pkg::PSADC_IDLE, psadc_pkg::PSADC_DONE:
				begin
					cnt_q <= '0;
					if (ctrlZero_q[psadc_pkg::START_SEL_POS] ?
						(wrRise || (state_q == psadc_pkg::PSADC_DONE && rdRise)) : stFall)
						state_q <= psadc_pkg::PSADC_SAMPLE;
				end
				psadc_pkg::PSADC_SAMPLE:
				begin
					cnt_q <= cnt_q + 5'h01;
					if (startConv)
					begin
						state_q <= psadc_pkg::PSADC_CONVERT;
						cnt_q <= '0;
					end
				end
				psadc_pkg::PSADC_CONVERT:
				begin
					cnt_q <= cnt_q + 5'h01;
					if (cnt_q == 5'(psadc_pkg::CONV_CYCLES - 1))
					begin
						state_q <= psadc_pkg::PSADC_DONE;
						result_q <= ctrlOne_q[psadc_pkg::TWOS_POS] ? {~trial[WIDTH-1], trial[WIDTH-2:0]} : trial;
					end
				end
			endcase
		end
	end

	// Power-down and completion outputs
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			idleCnt_q <= 2'h0;
			autoPowerDown <= 1'b0;
			swPowerDown <= 1'b0;
			intEocN <= 1'b1;
			sampleHold <= 1'b0;
			useExtClk <= 1'b0;
		end
		else if (clkEn)
		begin
			swPowerDown <= ctrlZero_q[psadc_pkg::SW_PD_POS] && !csActive;
			useExtClk <= ctrlZero_q[psadc_pkg::CLK_SEL_POS];
			sampleHold <= (state_q == psadc_pkg::PSADC_SAMPLE);
			if (state_q != psadc_pkg::PSADC_DONE || rdFall)
			begin
				idleCnt_q <= 2'h0;
				autoPowerDown <= 1'b0;
			end
			else if (idleCnt_q < 2'(psadc_pkg::AUTO_PD_CYCLES))
				idleCnt_q <= idleCnt_q + 2'h1;
			else
				autoPowerDown <= 1'b1;
			if (ctrlZero_q[psadc_pkg::EOC_MODE_POS])
				intEocN <= (state_q != psadc_pkg::PSADC_CONVERT);
			else
				intEocN <= !(tick && state_q == psadc_pkg::PSADC_CONVERT && cnt_q == 5'(psadc_pkg::CONV_CYCLES - 1));
		end
	end

	// Read port: drive only while read strobe is low
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			dataOe <= 1'b0;
			dataOut <= '0;
		end
		else if (clkEn)
		begin
			if (rdFall)
			begin
				dataOe <= 1'b1;
				dataOut <= result_q;
			end
			else if (!csActive || sync2_q.readN)
				dataOe <= 1'b0;
		end
	end

	// Independent tick count of each conversion, for the length check
	always_ff @(posedge core_clk or negedge reset_n)
	begin
		if (!reset_n)
			convTicks_q <= '0;
		else if (clkEn && state_q != psadc_pkg::PSADC_CONVERT)
			convTicks_q <= '0;
		else if (clkEn && tick)
			convTicks_q <= convTicks_q + 5'h01;
	end

	bus_quiet_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		clkEn && !csActive |=> !dataOe)
		else $error("Bus driven without chip select");
	read_drive_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		clkEn && rdFall |=> dataOe && dataOut == $past(result_q))
		else $error("Read not driven");
	default_load_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		clkEn && rdFall && !wrSeenHigh_q |=> ctrlZero_q == 6'h00 && ctrlOne_q == 6'h00)
		else $error("Defaults not loaded");
	cfg_write_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		clkEn && wrRise && wrSeenHigh_q && dataSync2_q[7:6] == 2'h0 |=> ctrlZero_q == $past(dataSync2_q[5:0]))
		else $error("Write lost");
	conv_len_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		$rose(state_q == psadc_pkg::PSADC_DONE) |-> convTicks_q == 5'(psadc_pkg::CONV_CYCLES))
		else $error("Conversion length");
	auto_pd_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		$rose(state_q == psadc_pkg::PSADC_DONE) && !rdFall && clkEn ##1 (clkEn && !rdFall)[*3] |=> autoPowerDown)
		else $error("No auto power-down");
	hw_start_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		clkEn && tick && startConv |=> state_q == psadc_pkg::PSADC_CONVERT)
		else $error("Start missed");
	eoc_level_a: assert property (@(posedge core_clk) disable iff (!reset_n)
		clkEn && ctrlZero_q[4] && state_q == psadc_pkg::PSADC_CONVERT |=> !intEocN)
		else $error("EOC level wrong");
	conv_done_c: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(state_q == psadc_pkg::PSADC_DONE));
	read_c: cover property (@(posedge core_clk) disable iff (!reset_n) rdFall && state_q == psadc_pkg::PSADC_DONE);
	sw_start_c: cover property (@(posedge core_clk) disable iff (!reset_n) wrRise && ctrlZero_q[5]);
	twos_c: cover property (@(posedge core_clk) disable iff (!reset_n) $rose(state_q == psadc_pkg::PSADC_DONE) && ctrlOne_q[1]);
endmodule

// ===== psadc_analog_model.sv
`timescale 1ns/10ps
module psadc_analog_model (
	input wire logic [7:0] dacCode,
	input wire logic [7:0] level,
	output logic compHigh
);
	// Ideal comparator, so the balanced code equals the input level
	assign compHigh = (level >= dacCode);
endmodule

// ===== parallel_sar_adc_host_port_tb.sv
`timescale 1ns/10ps
module parallel_sar_adc_host_port_tb;
	logic core_clk = 1'b0;
	logic ext_clk = 1'b0;
	logic reset_n = 1'b0;
	psadc_pkg::psadc_strobes_t stb = 4'hF;
	logic [7:0] hostData = 8'h00;
	logic [7:0] level = 8'hA5;
	logic [7:0] dataIn, dataOut, dacCode;
	logic dataOe, compHigh, sampleHold, intEocN, autoPowerDown, swPowerDown, useExtClk;
	int errorCnt = 0;
	int checked = 0;
	logic [7:0] rv;
	int n;
	always #25 core_clk = ~core_clk;
	always #37 ext_clk = ~ext_clk;
	// Host releases the bus while the device drives it
	assign dataIn = dataOe ? dataOut : hostData;
	psadc_analog_model model_u (.dacCode(dacCode), .level(level), .compHigh(compHigh));
	psadc_top dut_u (.core_clk(core_clk), .ext_clk(ext_clk), .reset_n(reset_n), .clkEn(1'b1),
		.strobesIn(stb), .dataIn(dataIn), .dataOut(dataOut), .dataOe(dataOe), .compHigh(compHigh),
		.dacCode(dacCode), .sampleHold(sampleHold), .intEocN(intEocN), .autoPowerDown(autoPowerDown),
		.swPowerDown(swPowerDown), .useExtClk(useExtClk));
	task automatic tick(int c);
		repeat (c) @(posedge core_clk);
		#5;
	endtask
	task automatic chk(string name, logic [7:0] seen, logic [7:0] exp);
		checked++;
		if (seen !== exp)
		begin
			$display("[FAIL] %s expected %h seen %h", name, exp, seen);
			errorCnt++;
		end
	endtask
	task automatic final_report;
		$display("Checks %0d, mismatches %0d", checked, errorCnt);
		if (errorCnt == 0 && checked > 0)
			$display("verification passed");
		else
			$display("verification failed");
		$finish;
	endtask
	// Host writes: address on the top two lines, held across the write rise
	task automatic wr(logic [1:0] a, logic [5:0] d, logic csN);
		hostData = {a, d};
		stb.chipSelN = csN;
		stb.writeN = 1'b0;
		tick(4);
		stb.writeN = 1'b1;
		tick(4);
		stb.chipSelN = 1'b1;
		tick(2);
	endtask
	task automatic rd(output logic [7:0] v);
		stb.chipSelN = 1'b0;
		stb.readN = 1'b0;
		tick(4);
		chk("dataOe in read", dataOe, 1);
		v = dataOut;
		stb.readN = 1'b1;
		stb.chipSelN = 1'b1;
		tick(3);
		chk("dataOe after read", dataOe, 0);
	endtask
	task automatic waitEoc(output int c);
		c = 0;
		while (intEocN !== 1'b0)
		begin
			tick(1);
			c++;
			if (c > 60)
			begin
				chk("eoc timeout", 1, 0);
				final_report();
			end
		end
	endtask
	task automatic testDefaults;
		// Write strobe still strapped low: dummy read loads zeros
		stb.chipSelN = 1'b0;
		stb.readN = 1'b0;
		tick(4);
		stb.readN = 1'b1;
		stb.chipSelN = 1'b1;
		tick(4);
		chk("useExtClk default", useExtClk, 0);
		chk("swPowerDown default", swPowerDown, 0);
		stb.writeN = 1'b1;
		tick(4);
		$display("test defaults done");
	endtask
	task automatic testHwStart;
		level = 8'hA5;
		stb.startN = 1'b0;
		tick(5);
		chk("sampleHold on start fall", sampleHold, 1);
		stb.startN = 1'b1;
		waitEoc(n);
		chk("conv length ok", (n >= 16 && n <= 22), 1);
		tick(3);
		chk("autoPowerDown", autoPowerDown, 1);
		rd(rv);
		chk("hw result", rv, 8'hA5);
		$display("test hw start done");
	endtask
	task automatic testSwStart;
		level = 8'h3C;
		wr(psadc_pkg::ADDR_CR0, 6'h20, 1'b0);
		// Start mode applies after the selecting write; the next write starts sampling
		wr(psadc_pkg::ADDR_CR1, 6'h00, 1'b0);
		waitEoc(n);
		// Three sampling clocks left after the write task, then sixteen conversion clocks
		chk("sw start to eoc", n, 19);
		tick(3);
		rd(rv);
		chk("sw result", rv, 8'h3C);
		wr(psadc_pkg::ADDR_CR0, 6'h00, 1'b0);
		$display("test sw start done");
	endtask
	task automatic testConfig;
		wr(psadc_pkg::ADDR_CR0, 6'h0C, 1'b0);
		chk("useExtClk set", useExtClk, 1);
		// Chip select release needs the sync stages plus one register
		tick(1);
		chk("swPowerDown cs high", swPowerDown, 1);
		wr(psadc_pkg::ADDR_CR1, 6'h00, 1'b0);
		chk("cr1 leaves cr0", useExtClk, 1);
		wr(psadc_pkg::ADDR_CR0, 6'h00, 1'b1);
		chk("write with cs high", useExtClk, 1);
		wr(psadc_pkg::ADDR_CR0, 6'h00, 1'b0);
		chk("useExtClk cleared", useExtClk, 0);
		$display("test config done");
	endtask
	task automatic testModes;
		// End-of-conversion level mode and twos complement output
		level = 8'hA5;
		wr(psadc_pkg::ADDR_CR0, 6'h10, 1'b0);
		wr(psadc_pkg::ADDR_CR1, 6'h02, 1'b0);
		stb.startN = 1'b0;
		tick(5);
		chk("eoc high before conversion", intEocN, 1);
		stb.startN = 1'b1;
		tick(5);
		chk("eoc low in conversion", intEocN, 0);
		tick(14);
		chk("eoc low at last clock", intEocN, 0);
		tick(1);
		chk("eoc high after conversion", intEocN, 1);
		rd(rv);
		chk("twos result", rv, 8'h25);
		$display("test modes done");
	endtask
	initial
	begin
		stb.writeN = 1'b0;
		tick(12);
		reset_n = 1'b1;
		chk("dataOe reset", dataOe, 0);
		chk("intEocN reset", intEocN, 1);
		tick(3);
		testDefaults();
		testHwStart();
		testSwStart();
		testConfig();
		testModes();
		final_report();
	end
endmodule
